// *** fets_pkg.sv ***
package fets_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_ERR_HIGH    = 12'h640;
    localparam logic [11:0] OFF_ERR_LOW     = 12'h644;
    localparam logic [11:0] OFF_BRIGHTNESS  = 12'h800;
    localparam logic [11:0] OFF_WHITE_BAL   = 12'h80C;
    localparam logic [11:0] OFF_SHUTTER     = 12'h81C;
    localparam logic [11:0] OFF_GAIN        = 12'h820;
    localparam logic [11:0] OFF_TRIGGER     = 12'h830;
    localparam logic [11:0] OFF_LIMIT_BASE  = 12'h900;
    localparam logic [11:0] OFF_STATUS      = 12'h940;

    // big-endian bit k sits at little-endian position 31-k
    localparam int          POS_ERR_BRIGHT  = 31 - 0;
    localparam int          POS_ERR_WBAL    = 31 - 3;
    localparam int          POS_ERR_SHUT    = 31 - 7;
    localparam int          POS_ERR_GAIN    = 31 - 8;
    localparam int          POS_ERR_TRIG    = 31 - 12;
    // trigger fields: mode = be bits 12..15, source = be bits 8..10
    localparam int          POS_TMODE_LO    = 31 - 15;
    localparam int          POS_TSRC_LO     = 31 - 10;
    localparam int          POS_TPOL        = 31 - 7;
    localparam int          VALUE_W         = 12;

    localparam logic [3:0]  TMODE_PROG      = 4'h0;
    localparam logic [3:0]  TMODE_LEVEL     = 4'h1;
    localparam logic [2:0]  TSRC_SOFTWARE   = 3'h7;
    localparam logic [2:0]  TSRC_EXT_MAX    = 3'h3;

    localparam logic [3:0]  TMODE_RESET     = 4'h0;
    localparam logic [2:0]  TSRC_RESET      = 3'h0;
    localparam logic        TPOL_RESET      = 1'h1;
    localparam logic [11:0] VALUE_RESET     = 12'h000;
    localparam logic [11:0] LIMIT_MIN_RESET = 12'h000;
    localparam logic [11:0] LIMIT_MAX_RESET = 12'hFFF;

    localparam int          NUM_FEAT        = 4;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
endpackage : fets_pkg

// *** fets_range_check.sv ***
`timescale 1ns/1ps
module fets_range_check (
    // setting and limits
    input  wire logic [11:0] value_in,
    input  wire logic [11:0] min_in,
    input  wire logic [11:0] max_in,
    // verdict
    output logic             bad_out
);
    assign bad_out = (value_in < min_in) || (value_in > max_in);
endmodule : fets_range_check

// *** fets_trig_check.sv ***
`timescale 1ns/1ps
module fets_trig_check (
    // trigger fields
    input  wire logic [3:0] mode_in,
    input  wire logic [2:0] source_in,
    // verdict
    output logic            bad_out
);
    wire logic src_ext  = (source_in <= fets_pkg::TSRC_EXT_MAX);
    wire logic src_soft = (source_in == fets_pkg::TSRC_SOFTWARE);
    wire logic mode_ok  = (mode_in == fets_pkg::TMODE_PROG)
                        || (mode_in == fets_pkg::TMODE_LEVEL);
    // external: both modes fine; software: programmable only
    assign bad_out = !mode_ok
                   || (src_soft && mode_in != fets_pkg::TMODE_PROG)
                   || (!src_ext && !src_soft);
endmodule : fets_trig_check

// *** fets_regs.sv ***
`timescale 1ns/1ps
module fets_regs #(
    parameter bit COLOUR_MODEL = 1'b1
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // avalon-mm slave
    input  wire logic [11:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // applied settings toward the imaging pipeline
    output logic [11:0]      brightness_out,
    output logic [11:0]      white_bal_out,
    output logic [11:0]      shutter_out,
    output logic [11:0]      gain_out,
    output logic [3:0]       trig_mode_out,
    output logic [2:0]       trig_source_out,
    output logic             trig_polarity_out,
    output logic             level_exposure_out,
    output logic             capture_enable_out
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} fets_bus_state_t;

    fets_bus_state_t state_q;
    fets_bus_state_t state_d;

    logic [11:0] value_q [fets_pkg::NUM_FEAT];
    logic [11:0] min_q   [fets_pkg::NUM_FEAT];
    logic [11:0] max_q   [fets_pkg::NUM_FEAT];
    logic [3:0]  tmode_q;
    logic [2:0]  tsrc_q;
    logic        tpol_q;
    logic [4:0]  err_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge of a 12-bit value held in the low bits
    function automatic logic [11:0] fets_merge12(input logic [11:0] old_v,
                                                  input logic [31:0] wd,
                                                  input logic [3:0]  be);
        logic [11:0] r;
        r = old_v;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[11:8] = wd[11:8];
        end
        return r;
    endfunction : fets_merge12

    function automatic logic [31:0] fets_low12(input logic [11:0] v);
        return {20'h00000, v};
    endfunction : fets_low12

    ////////////////////////////////////////////////////////////////////////
    // one wait cycle per access: request taken in idle, answered next edge
    wire logic req      = avs_read_in | avs_write_in;
    wire logic take     = req && (state_q == ST_IDLE);
    wire logic wr_take  = take && avs_write_in;
    wire logic [11:0] a = avs_address_in;

    wire logic hit_trig = (a == fets_pkg::OFF_TRIGGER);
    wire logic [3:0] hit_feat;
    wire logic [3:0] hit_min;
    wire logic [3:0] hit_max;
    assign hit_feat[0] = (a == fets_pkg::OFF_BRIGHTNESS);
    assign hit_feat[1] = (a == fets_pkg::OFF_WHITE_BAL) && COLOUR_MODEL;
    assign hit_feat[2] = (a == fets_pkg::OFF_SHUTTER);
    assign hit_feat[3] = (a == fets_pkg::OFF_GAIN);

    genvar g;
    generate
        for (g = 0; g < fets_pkg::NUM_FEAT; g++) begin : g_lim
            assign hit_min[g] = (a == fets_pkg::OFF_LIMIT_BASE + 12'(8 * g));
            assign hit_max[g] = (a == fets_pkg::OFF_LIMIT_BASE + 12'(8 * g + 4));
        end
    endgenerate

    // trigger register write data in little-endian positions
    wire logic [3:0] wr_tmode = avs_writedata_in[fets_pkg::POS_TMODE_LO +: 4];
    wire logic [2:0] wr_tsrc  = avs_writedata_in[fets_pkg::POS_TSRC_LO +: 3];
    wire logic       wr_tpol  = avs_writedata_in[fets_pkg::POS_TPOL];
    wire logic       trig_we  = wr_take && hit_trig && avs_byteenable_in[2]
                              && avs_byteenable_in[1];

    ////////////////////////////////////////////////////////////////////////
    // candidate values after this write, used by the checkers
    logic [11:0] new_val [fets_pkg::NUM_FEAT];
    logic [3:0]  feat_we;
    logic [3:0]  feat_bad;

    generate
        for (g = 0; g < fets_pkg::NUM_FEAT; g++) begin : g_feat
            assign feat_we[g] = wr_take && hit_feat[g];
            assign new_val[g] = fets_merge12(value_q[g], avs_writedata_in,
                                             avs_byteenable_in);
            fets_range_check u_chk (
                .value_in (new_val[g]),
                .min_in   (min_q[g]),
                .max_in   (max_q[g]),
                .bad_out  (feat_bad[g])
            );
        end
    endgenerate

    logic trig_bad;
    fets_trig_check u_trig_chk (
        .mode_in   (wr_tmode),
        .source_in (wr_tsrc),
        .bad_out   (trig_bad)
    );

    ////////////////////////////////////////////////////////////////////////
    // error high word, big-endian bit numbering
    wire logic [31:0] err_word;
    assign err_word = (32'(err_q[0]) << fets_pkg::POS_ERR_BRIGHT)
                    | (32'(err_q[1] & COLOUR_MODEL) << fets_pkg::POS_ERR_WBAL)
                    | (32'(err_q[2]) << fets_pkg::POS_ERR_SHUT)
                    | (32'(err_q[3]) << fets_pkg::POS_ERR_GAIN)
                    | (32'(err_q[4]) << fets_pkg::POS_ERR_TRIG);

    // unused trigger bits 0..15, 20 and 25..31 read zero
    wire logic [31:0] trig_word;
    assign trig_word = (32'(tpol_q) << fets_pkg::POS_TPOL)
                     | (32'(tsrc_q) << fets_pkg::POS_TSRC_LO)
                     | (32'(tmode_q) << fets_pkg::POS_TMODE_LO);

    wire logic [31:0] status_word;
    assign status_word = {27'h0000000, |err_q, level_exposure_out,
                          capture_enable_out, COLOUR_MODEL, 1'b1};

    always_comb begin
        rdata_d = fets_pkg::UNMAPPED_DATA;
        if (a == fets_pkg::OFF_ERR_HIGH) begin
            rdata_d = err_word;
        end else if (a == fets_pkg::OFF_ERR_LOW) begin
            rdata_d = 32'h0000_0000;
        end else if (hit_trig) begin
            rdata_d = trig_word;
        end else if (a == fets_pkg::OFF_STATUS) begin
            rdata_d = status_word;
        end
        for (int i = 0; i < fets_pkg::NUM_FEAT; i++) begin
            if (hit_feat[i]) begin
                rdata_d = fets_low12(value_q[i]);
            end
            if (hit_min[i]) begin
                rdata_d = fets_low12(min_q[i]);
            end
            if (hit_max[i]) begin
                rdata_d = fets_low12(max_q[i]);
            end
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (req) begin
                    state_d = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign avs_waitrequest_out = !(state_q == ST_ANSWER);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            if (take && avs_read_in) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign avs_readdata_out = rdata_q;

    // settings are stored even when out of range: capture runs on
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            for (int i = 0; i < fets_pkg::NUM_FEAT; i++) begin
                value_q[i] <= fets_pkg::VALUE_RESET;
                min_q[i]   <= fets_pkg::LIMIT_MIN_RESET;
                max_q[i]   <= fets_pkg::LIMIT_MAX_RESET;
            end
        end else begin
            for (int i = 0; i < fets_pkg::NUM_FEAT; i++) begin
                if (feat_we[i]) begin
                    value_q[i] <= new_val[i];
                end
                if (wr_take && hit_min[i]) begin
                    min_q[i] <= fets_merge12(min_q[i], avs_writedata_in,
                                             avs_byteenable_in);
                end
                if (wr_take && hit_max[i]) begin
                    max_q[i] <= fets_merge12(max_q[i], avs_writedata_in,
                                             avs_byteenable_in);
                end
            end
        end
    end

    // flags move only on writes to their own control register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            err_q <= 5'h00;
        end else begin
            for (int i = 0; i < fets_pkg::NUM_FEAT; i++) begin
                if (feat_we[i]) begin
                    err_q[i] <= feat_bad[i];
                end
            end
            if (trig_we) begin
                err_q[4] <= trig_bad;
            end
        end
    end

    // writes to the error words fall through: read-only
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            tmode_q <= fets_pkg::TMODE_RESET;
            tsrc_q  <= fets_pkg::TSRC_RESET;
            tpol_q  <= fets_pkg::TPOL_RESET;
        end else if (trig_we) begin
            tmode_q <= wr_tmode;
            tsrc_q  <= wr_tsrc;
            tpol_q  <= wr_tpol;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign brightness_out     = value_q[0];
    assign white_bal_out      = value_q[1];
    assign shutter_out        = value_q[2];
    assign gain_out           = value_q[3];
    assign trig_mode_out      = tmode_q;
    assign trig_source_out    = tsrc_q;
    assign trig_polarity_out  = tpol_q;
    assign level_exposure_out = (tmode_q == fets_pkg::TMODE_LEVEL);
    assign capture_enable_out = 1'b1;
endmodule : fets_regs

// *** fets_regs_props.sv ***
`timescale 1ns/1ps
module fets_regs_props (
    // clock and reset
    input wire logic        clock_in,
    input wire logic        rst_in,
    // bus
    input wire logic [11:0] avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    // applied settings
    input wire logic [11:0] brightness_out,
    input wire logic [3:0]  trig_mode_out,
    input wire logic        level_exposure_out,
    input wire logic        capture_enable_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_taken;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_wr_full(logic [11:0] a);
        avs_write_in && avs_waitrequest_out && avs_address_in == a && avs_byteenable_in == 4'hF;
    endsequence
    sequence s_rd_trig_done;
        avs_read_in && avs_waitrequest_out && avs_address_in == fets_pkg::OFF_TRIGGER
            ##1 !avs_waitrequest_out;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_wait_one_cycle: assert property (s_taken |=> !avs_waitrequest_out)
        else $error("answer not one cycle after request");
    a_wait_single_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer held longer than one cycle");
    a_idle_no_answer: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
        else $error("answer without request");
    a_level_mode_map: assert property (level_exposure_out == (trig_mode_out == fets_pkg::TMODE_LEVEL))
        else $error("level exposure does not follow mode");
    a_capture_kept_on: assert property (capture_enable_out == 1'b1)
        else $error("capture stopped");
    a_trig_mode_readback: assert property (s_rd_trig_done |->
        avs_readdata_out[fets_pkg::POS_TMODE_LO +: 4] == trig_mode_out)
        else $error("trigger mode read from wrong field");
    a_bright_value_applied: assert property (s_wr_full(fets_pkg::OFF_BRIGHTNESS) |=>
        brightness_out == $past(avs_writedata_in[11:0]))
        else $error("brightness setting not applied");
    a_trig_mode_applied: assert property (s_wr_full(fets_pkg::OFF_TRIGGER) |=>
        trig_mode_out == $past(avs_writedata_in[19:16]))
        else $error("trigger mode not applied");
    a_trig_reset_value: assert property ($fell(rst_in) |-> trig_mode_out == fets_pkg::TMODE_RESET)
        else $error("trigger mode reset value wrong");
endmodule : fets_regs_props
bind fets_regs fets_regs_props u_props (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .brightness_out(brightness_out),
    .trig_mode_out(trig_mode_out), .level_exposure_out(level_exposure_out),
    .capture_enable_out(capture_enable_out)
);

// *** fets_host.sv ***
`timescale 1ns/1ps
module fets_host (
    // clock
    input  wire logic        clock_in,
    // bus master
    output logic [11:0]      avs_address_out,
    output logic             avs_read_out,
    output logic             avs_write_out,
    output logic [31:0]      avs_writedata_out,
    output logic [3:0]       avs_byteenable_out,
    input  wire logic [31:0] avs_readdata_in,
    input  wire logic        avs_waitrequest_in
);
    initial begin
        avs_address_out = 12'h000;
        avs_read_out = 1'b0;
        avs_write_out = 1'b0;
        avs_writedata_out = 32'h0000_0000;
        avs_byteenable_out = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // host ignores bits that carry nothing in the error high and trigger words
    function automatic logic [31:0] keep_mask(logic [11:0] a);
        if (a == fets_pkg::OFF_ERR_HIGH) return 32'h9188_0000;
        if (a == fets_pkg::OFF_TRIGGER) return 32'h01EF_0000;
        return 32'hFFFF_FFFF;
    endfunction : keep_mask
    // one idle edge first, so release and next request never share a time step
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        q = 32'hXXXX_XXXX;
        @(posedge clock_in);
        avs_read_out <= !wr;
        avs_write_out <= wr;
        avs_address_out <= a;
        avs_writedata_out <= d;
        do begin
            @(posedge clock_in);
            n++;
        end while (avs_waitrequest_in !== 1'b0 && n < 50);
        if (n < 50) q = avs_readdata_in & keep_mask(a);
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        avs_writedata_out <= ~d;
    endtask : xfer
endmodule : fets_host

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    logic clock_in;
    logic rst_in;
    logic [11:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [11:0] brightness_out, white_bal_out, shutter_out, gain_out;
    logic [3:0] trig_mode_out;
    logic [2:0] trig_source_out;
    logic trig_polarity_out, level_exposure_out, capture_enable_out;
    logic [11:0] applied [4];
    int bad_count = 0;
    int num_checks = 0;
    localparam logic [11:0] FOFF [4] = '{fets_pkg::OFF_BRIGHTNESS, fets_pkg::OFF_WHITE_BAL,
                                         fets_pkg::OFF_SHUTTER, fets_pkg::OFF_GAIN};
    localparam int FPOS [4] = '{fets_pkg::POS_ERR_BRIGHT, fets_pkg::POS_ERR_WBAL,
                                fets_pkg::POS_ERR_SHUT, fets_pkg::POS_ERR_GAIN};
    localparam logic [11:0] VAL [4] = '{12'h00F, 12'h010, 12'h101, 12'h100};
    localparam logic [2:0] TSRC [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h7, 3'h2};
    localparam logic [3:0] TMOD [6] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h2};
    localparam logic TBAD [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    always_comb applied = '{brightness_out, white_bal_out, shutter_out, gain_out};

    fets_regs #(.COLOUR_MODEL(1'b1)) uut (
        .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .brightness_out(brightness_out), .white_bal_out(white_bal_out),
        .shutter_out(shutter_out), .gain_out(gain_out), .trig_mode_out(trig_mode_out),
        .trig_source_out(trig_source_out), .trig_polarity_out(trig_polarity_out),
        .level_exposure_out(level_exposure_out), .capture_enable_out(capture_enable_out));
    fets_host host (
        .clock_in(clock_in), .avs_address_out(avs_address_in), .avs_read_out(avs_read_in),
        .avs_write_out(avs_write_in), .avs_writedata_out(avs_writedata_in),
        .avs_byteenable_out(avs_byteenable_in), .avs_readdata_in(avs_readdata_out),
        .avs_waitrequest_in(avs_waitrequest_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(logic [11:0] a, string name, logic [31:0] exp);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0000_0000, q);
        check(name, q, exp);
    endtask : rd
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // whole run needs some 81 accesses of three cycles each
    initial begin
        repeat (20000) @(posedge clock_in);
        bad_count++;
        $display("Error watchdog expected done seen hang");
        finish_test();
    end
    initial begin
        logic [31:0] d;
        rst_in = 1'b1;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(fets_pkg::OFF_TRIGGER, "trigger reset", 32'h0100_0000);
        rd(fets_pkg::OFF_ERR_HIGH, "flags reset", 32'h0000_0000);
        rd(12'hA00, "unmapped read", fets_pkg::UNMAPPED_DATA);
        // each feature: below min, at min, above max, at max
        for (int i = 0; i < 4; i++) begin
            wr(fets_pkg::OFF_LIMIT_BASE + 12'(8 * i), 32'h0000_0010);
            wr(fets_pkg::OFF_LIMIT_BASE + 12'(8 * i + 4), 32'h0000_0100);
            for (int v = 0; v < 4; v++) begin
                wr(FOFF[i], {20'h0, VAL[v]});
                rd(fets_pkg::OFF_ERR_HIGH, "error flag", TBAD[0] | (VAL[v] == 12'h00F || VAL[v] == 12'h101) ? 32'h1 << FPOS[i] : 32'h0);
                rd(FOFF[i], "setting readback", {20'h0, VAL[v]});
                check("applied setting", {20'h0, applied[i]}, {20'h0, VAL[v]});
                check("capture enable", {31'h0, capture_enable_out}, 32'h1);
            end
        end
        // host write must not touch the flags
        wr(fets_pkg::OFF_GAIN, 32'h0000_0101);
        wr(fets_pkg::OFF_ERR_HIGH, 32'h0000_0000);
        rd(fets_pkg::OFF_ERR_HIGH, "flag read only", 32'h1 << fets_pkg::POS_ERR_GAIN);
        wr(fets_pkg::OFF_GAIN, 32'h0000_0100);
        // trigger source and mode pairs, junk in unused bits 0..15
        for (int t = 0; t < 6; t++) begin
            d = {7'h0, 1'b1, TSRC[t], 1'b0, TMOD[t], 16'h0000};
            wr(fets_pkg::OFF_TRIGGER, d | 32'h0000_FFFF);
            rd(fets_pkg::OFF_TRIGGER, "trigger readback", d);
            check("trigger mode", {28'h0, trig_mode_out}, {28'h0, TMOD[t]});
            check("level exposure", {31'h0, level_exposure_out}, {31'h0, TMOD[t] == 4'h1});
            rd(fets_pkg::OFF_ERR_HIGH, "trigger flag", TBAD[t] ? 32'h1 << fets_pkg::POS_ERR_TRIG : 32'h0);
        end
        finish_test();
    end
endmodule : tb
